// ### logic/sic_pkg.sv
`default_nettype none
package sic_pkg;

  // ----------------------------------------------------------------------
  // i/o register offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] SIC_IO_SPL        = 6'h3D;
  localparam logic [5:0] SIC_IO_SPH        = 6'h3E;
  localparam logic [5:0] SIC_IO_STATUS     = 6'h3F;
  localparam logic [5:0] SIC_IO_CORE_CTRL  = 6'h35;
  localparam logic [5:0] SIC_IO_IRQ_FLAGS  = 6'h1C;
  localparam logic [5:0] SIC_IO_IRQ_ENABLE = 6'h1D;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         SIC_GIE_BIT       = 7;
  localparam int         SIC_VTS_BIT       = 1;
  localparam logic [15:0] SIC_LAST_SRAM_ADDRESS = 16'h02FF;
  localparam logic [15:0] SIC_BOOT_START    = 16'h0C00;
  localparam logic [15:0] SIC_VEC_STRIDE    = 16'h0001;
  localparam logic [15:0] SIC_PTR_RESET     = 16'h0000;
  localparam logic [15:0] SIC_ONE_BYTE      = 16'h0001;
  localparam logic [15:0] SIC_RET_BYTES     = 16'h0002;
  localparam logic [7:0]  SIC_BYTE_ZERO     = 8'h00;
  localparam logic [3:0]  SIC_CNT_ZERO      = 4'h0;

  // ----------------------------------------------------------------------
  // timing in core clock cycles
  // ----------------------------------------------------------------------
  localparam logic [3:0] SIC_RESP_CYCLES = 4'h4;
  localparam logic [3:0] SIC_WAKE_CYCLES = 4'h4;
  localparam logic [3:0] SIC_INTERRUPT_EXIT_INSTR_CYCLES = 4'h4;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SIC_STK_NONE = 3'b000,
    SIC_STK_PUSH = 3'b001,
    SIC_STK_POP  = 3'b010,
    SIC_STK_CALL = 3'b011,
    SIC_STK_RET  = 3'b100,
    SIC_STK_INTERRUPT_EXIT_INSTR = 3'b101
  } sic_stack_cmd_type;

  typedef enum logic [1:0] {
    SIC_PTR_PLAIN   = 2'b00,
    SIC_PTR_DISP    = 2'b01,
    SIC_PTR_POSTINC = 2'b10,
    SIC_PTR_PREDEC  = 2'b11
  } sic_ptr_mode_type;

  typedef enum logic [2:0] {
    SIC_ALU_MOV = 3'b000,
    SIC_ALU_ADD = 3'b001,
    SIC_ALU_SUB = 3'b010,
    SIC_ALU_AND = 3'b011,
    SIC_ALU_OR  = 3'b100,
    SIC_ALU_XOR = 3'b101
  } sic_alu_op_type;

  typedef enum logic [1:0] {
    SIC_IRQ_IDLE  = 2'b00,
    SIC_IRQ_ENTRY = 2'b01,
    SIC_IRQ_EXIT  = 2'b10
  } sic_irq_state_type;

  typedef struct packed {
    logic             valid;
    logic [1:0]       sel;
    sic_ptr_mode_type mode;
    logic [5:0]       disp;
  } sic_ptr_req_type;

  typedef struct packed {
    logic           valid;
    sic_alu_op_type op;
    logic [2:0]     dst;
    logic [2:0]     src;
  } sic_alu_req_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sic_io_req_type;

  typedef struct packed {
    logic [15:0] value;
  } sic_ptr_state_type;

  typedef struct packed {
    logic [15:0]       sp;
    logic              gie;
    logic              vts;
    logic [7:0]        flags;
    logic [7:0]        enables;
    logic              hold;
    sic_irq_state_type st;
    logic [3:0]        cnt;
    logic [15:0]       vector;
    logic              take;
    logic              busy;
    logic [7:0]        rdata;
    logic [15:0]       ptr_addr;
    logic [15:0]       stack_addr;
    logic [15:0]       reset_vector;
    logic [7:0]        lvl_s1;
    logic [7:0]        lvl_s2;
    logic [2:0]        fuse_s1;
    logic [2:0]        fuse_s2;
  } sic_core_state_type;

endpackage : sic_pkg
`default_nettype wire

// ### logic/sic_ptr_pair.sv
`timescale 1ns/1ps
`default_nettype none
module sic_ptr_pair
  import sic_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // byte writes
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  lo_in,
  input  wire logic [7:0]  hi_in,
  // pointer value
  output logic      [15:0] value
);

  sic_ptr_state_type s_r;
  sic_ptr_state_type s_nxt;

  // ----------------------------------------------------------------------
  // byte-wise update of one pointer pair
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (wr_lo) begin
      s_nxt.value[7:0] = lo_in;
    end
    if (wr_hi) begin
      s_nxt.value[15:8] = hi_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.value <= SIC_PTR_RESET;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign value = s_r.value;

endmodule // sic_ptr_pair
`default_nettype wire

// ### logic/sic_core.sv
// Overview of operation
// - R26..R31 form three 16-bit pointer pairs
// - pointers support displacement, post-increment, pre-decrement
// - stack grows downward, pointer marks top
// - push decrements by one, pop increments
// - calls, entry minus two; returns plus two
// - pointer in two bytes; high byte optional
// - pointer resets to last sram address
// - core runs on undivided clock
// - two-register alu op completes in one cycle
// - take needs local and global enable
// - boot lock bits may suppress interrupts
// - low vectors first; lower vector, higher priority
// - select bit and fuse relocate vectors
// - entry clears global enable; exit sets it
// - vectoring or writing one clears flag
// - disabled flags stay latched, served by priority
// - level requests only while condition persists
// - one main instruction runs after exit
// - status register not saved by hardware
// - disable instruction blocks interrupts at once
// - instruction after enable always executes
// - entry takes four cycles, plus four from sleep
// - exit takes four cycles, sets global enable
`timescale 1ns/1ps
`default_nettype none
module sic_core
  import sic_pkg::*;
#(
  parameter int          IRQ_COUNT  = 8,
  parameter int          SP_WIDTH   = 10,
  parameter logic [15:0] LAST_SRAM  = SIC_LAST_SRAM_ADDRESS,
  parameter logic [15:0] BOOT_START = SIC_BOOT_START,
  parameter logic [15:0] VEC_STRIDE = SIC_VEC_STRIDE,
  parameter logic [7:0]  LEVEL_MASK = 8'h00
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // i/o register port
  input  wire sic_io_req_type       io_req,
  output logic [7:0]                io_rdata,
  // instruction timing from the core
  input  wire logic                 instr_done,
  input  wire logic                 sei_instr,
  input  wire logic                 cli_instr,
  input  wire logic                 sleeping,
  input  wire logic [15:0]          pc_in,
  // stack
  input  wire sic_stack_cmd_type    stack_cmd,
  output logic [15:0]               stack_pointer,
  output logic [15:0]               stack_addr,
  // pointer pairs
  input  wire sic_ptr_req_type      ptr_req,
  input  wire sic_alu_req_type      alu_req,
  input  wire logic                 rf_wr_en,
  input  wire logic [2:0]           rf_wr_idx,
  input  wire logic [7:0]           rf_wr_data,
  output logic [15:0]               ptr_addr,
  output logic [47:0]               ptr_pairs,
  // interrupt sources and straps
  input  wire logic [IRQ_COUNT-1:0] irq_event,
  input  wire logic [IRQ_COUNT-1:0] irq_level_pin,
  input  wire logic                 reset_vector_relocate_fuse,
  input  wire logic                 boot_lock_app_bit,
  input  wire logic                 boot_lock_loader_bit,
  // interrupt answer
  output logic                      irq_take,
  output logic [15:0]               irq_vector,
  output logic                      core_busy,
  output logic                      global_irq_enable,
  output logic [15:0]               reset_vector
);

  // ----------------------------------------------------------------------
  // elaboration checks and constants
  // ----------------------------------------------------------------------
  if (IRQ_COUNT < 1 || IRQ_COUNT > 8) begin : g_bad_irq
    $error("IRQ_COUNT must lie in 1..8");
  end
  if (SP_WIDTH < 8 || SP_WIDTH > 16) begin : g_bad_sp
    $error("SP_WIDTH must lie in 8..16");
  end

  localparam logic        HAS_SPH  = (SP_WIDTH > 8);
  localparam logic [15:0] SP_MASK  = 16'((32'h1 << SP_WIDTH) - 1);
  localparam logic [7:0]  IRQ_MASK = 8'((32'h1 << IRQ_COUNT) - 1);

  sic_core_state_type s_r;
  sic_core_state_type s_nxt;

  logic [15:0] pval [3];
  logic [7:0]  pbyte [6];
  logic [5:0]  bwen;
  logic [7:0]  bdat [6];
  logic [7:0]  pending;
  logic [2:0]  win_idx;
  logic        take_c;
  logic        gie_eff;
  logic        boot_block;
  logic [15:0] vbase;
  logic [15:0] step_val;
  logic [7:0]  alu_a;
  logic [7:0]  alu_b;
  logic [7:0]  alu_y;

  // ----------------------------------------------------------------------
  // pointer pairs
  // ----------------------------------------------------------------------
  // three pointer pairs
  for (genvar g = 0; g < 3; g++) begin : g_pair
    sic_ptr_pair u_pair (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr_lo   (bwen[2*g]),
      .wr_hi   (bwen[2*g+1]),
      .lo_in   (bdat[2*g]),
      .hi_in   (bdat[2*g+1]),
      .value   (pval[g])
    );
    assign pbyte[2*g]   = pval[g][7:0];
    assign pbyte[2*g+1] = pval[g][15:8];
  end

  // ----------------------------------------------------------------------
  // pointer byte writes: step, alu, then register file
  // ----------------------------------------------------------------------
  always_comb begin
    bwen  = '0;
    alu_a = SIC_BYTE_ZERO;
    alu_b = SIC_BYTE_ZERO;
    alu_y = SIC_BYTE_ZERO;
    step_val = pval[ptr_req.sel];
    for (int b = 0; b < 6; b++) begin
      bdat[b] = pbyte[b];
    end
    if (ptr_req.valid && ptr_req.sel != 2'd3) begin
      if (ptr_req.mode == SIC_PTR_POSTINC) begin
        step_val = pval[ptr_req.sel] + SIC_ONE_BYTE;
      end else if (ptr_req.mode == SIC_PTR_PREDEC) begin
        step_val = pval[ptr_req.sel] - SIC_ONE_BYTE;
      end
      if (ptr_req.mode == SIC_PTR_POSTINC ||
          ptr_req.mode == SIC_PTR_PREDEC) begin
        bwen[2*ptr_req.sel]   = 1'b1;
        bwen[2*ptr_req.sel+1] = 1'b1;
        bdat[2*ptr_req.sel]   = step_val[7:0];
        bdat[2*ptr_req.sel+1] = step_val[15:8];
      end
    end
    if (alu_req.valid && alu_req.dst < 3'd6 && alu_req.src < 3'd6) begin
      alu_a = pbyte[alu_req.dst];
      alu_b = pbyte[alu_req.src];
      unique case (alu_req.op)
        SIC_ALU_MOV: alu_y = alu_b;
        SIC_ALU_ADD: alu_y = alu_a + alu_b;
        SIC_ALU_SUB: alu_y = alu_a - alu_b;
        SIC_ALU_AND: alu_y = alu_a & alu_b;
        SIC_ALU_OR:  alu_y = alu_a | alu_b;
        SIC_ALU_XOR: alu_y = alu_a ^ alu_b;
        default:     alu_y = alu_a;
      endcase
      bwen[alu_req.dst] = 1'b1;
      bdat[alu_req.dst] = alu_y;
    end
    if (rf_wr_en && rf_wr_idx < 3'd6) begin
      bwen[rf_wr_idx] = 1'b1;
      bdat[rf_wr_idx] = rf_wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    pending = ((s_r.flags & ~LEVEL_MASK) | (s_r.lvl_s2 & LEVEL_MASK))
              & s_r.enables & IRQ_MASK;
    win_idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (pending[i]) begin
        win_idx = 3'(i);
      end
    end
    gie_eff = s_r.gie && !cli_instr;
    boot_block = (!s_r.vts && pc_in >= BOOT_START && s_r.fuse_s2[2]) ||
                 (s_r.vts && pc_in < BOOT_START && s_r.fuse_s2[1]);
    vbase = s_r.vts ? BOOT_START : 16'h0000;
    take_c = instr_done && s_r.st == SIC_IRQ_IDLE && gie_eff &&
             !s_r.hold && !sei_instr && !boot_block && (|pending) &&
             stack_cmd == SIC_STK_NONE;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.take = 1'b0;
    s_nxt.lvl_s1 = 8'(irq_level_pin);
    s_nxt.lvl_s2 = s_r.lvl_s1;
    s_nxt.fuse_s1 = {boot_lock_loader_bit, boot_lock_app_bit,
                     reset_vector_relocate_fuse};
    s_nxt.fuse_s2 = s_r.fuse_s1;
    s_nxt.reset_vector = s_r.fuse_s2[0] ? BOOT_START : 16'h0000;
    if (ptr_req.valid && ptr_req.sel != 2'd3) begin
      unique case (ptr_req.mode)
        SIC_PTR_PLAIN:   s_nxt.ptr_addr = pval[ptr_req.sel];
        SIC_PTR_DISP:    s_nxt.ptr_addr = pval[ptr_req.sel] +
                                          16'(ptr_req.disp);
        SIC_PTR_POSTINC: s_nxt.ptr_addr = pval[ptr_req.sel];
        SIC_PTR_PREDEC:  s_nxt.ptr_addr = step_val;
      endcase
    end
    // i/o reads return registered data
    if (io_req.rd) begin
      unique case (io_req.addr)
        SIC_IO_SPL:        s_nxt.rdata = s_r.sp[7:0];
        SIC_IO_SPH:        s_nxt.rdata = HAS_SPH ? s_r.sp[15:8] : 8'h00;
        SIC_IO_STATUS:     s_nxt.rdata = 8'(s_r.gie) << SIC_GIE_BIT;
        SIC_IO_CORE_CTRL:  s_nxt.rdata = 8'(s_r.vts) << SIC_VTS_BIT;
        SIC_IO_IRQ_FLAGS:  s_nxt.rdata = s_r.flags;
        SIC_IO_IRQ_ENABLE: s_nxt.rdata = s_r.enables;
        default:           s_nxt.rdata = SIC_BYTE_ZERO;
      endcase
    end
    if (io_req.wr) begin
      if (io_req.addr == SIC_IO_SPL) begin
        s_nxt.sp = {s_r.sp[15:8], io_req.wdata} & SP_MASK;
      end
      if (io_req.addr == SIC_IO_SPH && HAS_SPH) begin
        s_nxt.sp = {io_req.wdata, s_r.sp[7:0]} & SP_MASK;
      end
      // only the enable bit lives here
      if (io_req.addr == SIC_IO_STATUS) begin
        s_nxt.gie = io_req.wdata[SIC_GIE_BIT];
      end
      if (io_req.addr == SIC_IO_CORE_CTRL) begin
        s_nxt.vts = io_req.wdata[SIC_VTS_BIT];
      end
      if (io_req.addr == SIC_IO_IRQ_ENABLE) begin
        s_nxt.enables = io_req.wdata & IRQ_MASK;
      end
      if (io_req.addr == SIC_IO_IRQ_FLAGS) begin
        s_nxt.flags = s_r.flags & ~io_req.wdata;
      end
    end
    if (sei_instr && instr_done) begin
      s_nxt.gie = 1'b1;
      s_nxt.hold = 1'b1;
    end else if (instr_done && s_r.st == SIC_IRQ_IDLE) begin
      s_nxt.hold = 1'b0;
    end
    if (cli_instr) begin
      s_nxt.gie = 1'b0;
    end
    if (s_r.st == SIC_IRQ_IDLE) begin
      unique case (stack_cmd)
        SIC_STK_NONE: ;
        SIC_STK_PUSH: begin
          s_nxt.stack_addr = s_r.sp;
          s_nxt.sp = (s_r.sp - SIC_ONE_BYTE) & SP_MASK;
        end
        SIC_STK_POP: begin
          s_nxt.sp = (s_r.sp + SIC_ONE_BYTE) & SP_MASK;
          s_nxt.stack_addr = s_nxt.sp;
        end
        SIC_STK_CALL: begin
          s_nxt.stack_addr = s_r.sp;
          s_nxt.sp = (s_r.sp - SIC_RET_BYTES) & SP_MASK;
        end
        SIC_STK_RET: begin
          s_nxt.stack_addr = (s_r.sp + SIC_ONE_BYTE) & SP_MASK;
          s_nxt.sp = (s_r.sp + SIC_RET_BYTES) & SP_MASK;
        end
        SIC_STK_INTERRUPT_EXIT_INSTR: begin
          s_nxt.stack_addr = (s_r.sp + SIC_ONE_BYTE) & SP_MASK;
          s_nxt.sp = (s_r.sp + SIC_RET_BYTES) & SP_MASK;
          s_nxt.st = SIC_IRQ_EXIT;
          s_nxt.cnt = SIC_INTERRUPT_EXIT_INSTR_CYCLES - 4'h1;
          s_nxt.busy = 1'b1;
        end
        default: ;
      endcase
    end
    // interrupt sequencer
    unique case (s_r.st)
      SIC_IRQ_IDLE: begin
        if (take_c) begin
          s_nxt.take = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.st = SIC_IRQ_ENTRY;
          s_nxt.cnt = SIC_RESP_CYCLES - 4'h1 +
                      (sleeping ? SIC_WAKE_CYCLES : SIC_CNT_ZERO);
          s_nxt.gie = 1'b0;
          s_nxt.vector = vbase + (16'(win_idx) + 16'h0001) * VEC_STRIDE;
          s_nxt.stack_addr = s_r.sp;
          s_nxt.sp = (s_r.sp - SIC_RET_BYTES) & SP_MASK;
          s_nxt.flags[win_idx] = s_nxt.flags[win_idx] & LEVEL_MASK[win_idx];
        end
      end
      SIC_IRQ_ENTRY: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == SIC_CNT_ZERO) begin
          s_nxt.st = SIC_IRQ_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      SIC_IRQ_EXIT: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == SIC_CNT_ZERO) begin
          s_nxt.st = SIC_IRQ_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.gie = 1'b1;
          s_nxt.hold = 1'b1;
        end
      end
      default: s_nxt.st = SIC_IRQ_IDLE;
    endcase
    s_nxt.flags = (s_nxt.flags | 8'(irq_event)) & IRQ_MASK & ~LEVEL_MASK;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // undivided core clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.sp <= LAST_SRAM;
      s_r.st <= SIC_IRQ_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign io_rdata          = s_r.rdata;
  assign stack_pointer     = s_r.sp;
  assign stack_addr        = s_r.stack_addr;
  assign ptr_addr          = s_r.ptr_addr;
  assign ptr_pairs         = {pval[2], pval[1], pval[0]};
  assign irq_take          = s_r.take;
  assign irq_vector        = s_r.vector;
  assign core_busy         = s_r.busy;
  assign global_irq_enable = s_r.gie;
  assign reset_vector      = s_r.reset_vector;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  AST_RESET_SP: assert property (
    $past(rst) |-> s_r.sp == LAST_SRAM) else $error("sp not at reset value");
  AST_PUSH_DEC: assert property (
    stack_cmd == SIC_STK_PUSH && s_r.st == SIC_IRQ_IDLE && !io_req.wr
    |=> s_r.sp == (($past(s_r.sp) - SIC_ONE_BYTE) & SP_MASK))
    else $error("push did not decrement by one");
  AST_RET_INC: assert property (
    stack_cmd == SIC_STK_RET && s_r.st == SIC_IRQ_IDLE && !io_req.wr
    |=> s_r.sp == (($past(s_r.sp) + SIC_RET_BYTES) & SP_MASK))
    else $error("return did not increment by two");
  AST_TAKE_ENABLED: assert property (
    take_c |-> s_r.gie && (|(s_r.enables & IRQ_MASK)))
    else $error("interrupt taken while disabled");
  AST_CLI_BLOCKS: assert property (
    cli_instr |=> !s_r.take) else $error("interrupt after disable");
  AST_ENTRY_GIE: assert property (
    s_r.take |-> !s_r.gie && s_r.busy) else $error("entry kept enable");
  AST_ENTRY_LEN: assert property (
    s_r.take && !$past(sleeping) |-> s_r.busy [*4] ##1 !s_r.busy)
    else $error("entry length not four cycles");
  AST_EXIT_GIE: assert property (
    stack_cmd == SIC_STK_INTERRUPT_EXIT_INSTR && s_r.st == SIC_IRQ_IDLE
    |=> s_r.busy [*4] ##1 (s_r.gie && s_r.hold))
    else $error("exit did not restore enable in four cycles");
  AST_HOLD_BLOCKS: assert property (
    s_r.hold |-> !take_c) else $error("interrupt before held instruction");
  AST_FLAG_SET_WINS: assert property (
    (irq_event[0] && !LEVEL_MASK[0]) |=> s_r.flags[0])
    else $error("flag event lost");

  COV_TAKE: cover property (s_r.take);
  COV_NEST: cover property (s_r.take ##[1:40] s_r.take);
  COV_INTERRUPT_EXIT_INSTR: cover property (s_r.st == SIC_IRQ_EXIT);
  COV_WAKE: cover property (take_c && sleeping);

endmodule // sic_core
`default_nettype wire

// ### bench/sic_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sic_core_tb;
  import sic_pkg::*;
  // --------------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------------
  logic ref_clk = 1'b0, rst = 1'b1, instr_done = 1'b0;
  logic sei_instr = 1'b0, cli_instr = 1'b0, rf_wr_en = 1'b0;
  logic reset_vector_relocate_fuse = 1'b1;
  logic [15:0] pc_in = 16'h0000;
  logic [2:0] rf_wr_idx = 3'h0;
  logic [7:0] rf_wr_data = 8'h00, irq_event = 8'h00, io_rdata;
  sic_io_req_type io_req = '0;
  sic_stack_cmd_type stack_cmd = SIC_STK_NONE;
  sic_ptr_req_type ptr_req = '0;
  sic_alu_req_type alu_req = '0;
  logic [15:0] stack_pointer, stack_addr, ptr_addr, irq_vector, reset_vector;
  logic [47:0] ptr_pairs;
  logic irq_take, core_busy, global_irq_enable;
  int mismatches = 0, tests_run = 0, cyc = 0;
  logic [15:0] sp, x;
  logic [7:0] rb [3];
  int a;
  sic_stack_cmd_type c;
  sic_stack_cmd_type cmds [4] = '{SIC_STK_PUSH, SIC_STK_POP, SIC_STK_CALL,
                                  SIC_STK_RET};

  sic_core sic_core_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .io_req(io_req), .io_rdata(io_rdata), .instr_done(instr_done),
    .sei_instr(sei_instr), .cli_instr(cli_instr), .sleeping(1'b0),
    .pc_in(pc_in), .stack_cmd(stack_cmd), .stack_pointer(stack_pointer),
    .stack_addr(stack_addr), .ptr_req(ptr_req), .alu_req(alu_req),
    .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data),
    .ptr_addr(ptr_addr), .ptr_pairs(ptr_pairs), .irq_event(irq_event),
    .irq_level_pin(8'h00),
    .reset_vector_relocate_fuse(reset_vector_relocate_fuse),
    .boot_lock_app_bit(1'b0), .boot_lock_loader_bit(1'b0),
    .irq_take(irq_take), .irq_vector(irq_vector), .core_busy(core_busy),
    .global_irq_enable(global_irq_enable), .reset_vector(reset_vector));

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      close_out();
    end
  end

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic io(input logic w, input logic [5:0] ad, input logic [7:0] d);
    @(posedge ref_clk) io_req <= '{w, !w, ad, d};
    @(posedge ref_clk) io_req <= '0;
    #1;
  endtask
  task automatic stk(input sic_stack_cmd_type k);
    @(posedge ref_clk) stack_cmd <= k;
    @(posedge ref_clk) stack_cmd <= SIC_STK_NONE;
    #1;
  endtask
  task automatic ev(input logic [7:0] b);
    @(posedge ref_clk) irq_event <= b;
    @(posedge ref_clk) irq_event <= 8'h00;
  endtask
  task automatic instr(input logic s, input logic k);
    @(posedge ref_clk) begin
      instr_done <= 1'b1;
      sei_instr <= s;
      cli_instr <= k;
      pc_in <= 16'($urandom_range(32'h0BFF));
    end
    @(posedge ref_clk) begin
      instr_done <= 1'b0;
      sei_instr <= 1'b0;
      cli_instr <= 1'b0;
    end
    #1;
  endtask
  function automatic logic [15:0] nsp(sic_stack_cmd_type k, logic [15:0] s);
    case (k)
      SIC_STK_PUSH: return (s - 16'h0001) & 16'h03FF;
      SIC_STK_POP:  return (s + 16'h0001) & 16'h03FF;
      SIC_STK_CALL: return (s - 16'h0002) & 16'h03FF;
      default:      return (s + 16'h0002) & 16'h03FF;
    endcase
  endfunction
  task automatic close_out;
    $display("counts tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(32'hA3B58B90));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("sp", 16'h02FF, stack_pointer);
    io(1'b0, SIC_IO_SPL, 8'h00);
    chk("spl", 16'h00FF, {8'h00, io_rdata});
    io(1'b0, SIC_IO_SPH, 8'h00);
    chk("sph", 16'h0002, {8'h00, io_rdata});
    chk("rvec", SIC_BOOT_START, reset_vector);
    $display("test reset done");
    sp = 16'($urandom_range(32'h02FF, 32'h0200));
    io(1'b1, SIC_IO_SPL, sp[7:0]);
    io(1'b1, SIC_IO_SPH, sp[15:8]);
    for (int i = 0; i < 12; i++) begin
      c = cmds[$urandom_range(3)];
      stk(c);
      x = (c == SIC_STK_PUSH || c == SIC_STK_CALL) ? sp : sp + 16'h0001;
      sp = nsp(c, sp);
      chk("sp", sp, stack_pointer);
      chk("saddr", x, stack_addr);
    end
    $display("test stack done");
    for (int i = 0; i < 3; i++) begin
      rb[i] = 8'($urandom);
      @(posedge ref_clk) begin
        rf_wr_en <= 1'b1;
        rf_wr_idx <= 3'(i);
        rf_wr_data <= rb[i];
      end
    end
    @(posedge ref_clk) rf_wr_en <= 1'b0;
    alu_req <= '{1'b1, SIC_ALU_ADD, 3'h0, 3'h2};
    @(posedge ref_clk) alu_req <= '0;
    #1;
    x = {rb[1], rb[0] + rb[2]};
    chk("x", x, ptr_pairs[15:0]);
    @(posedge ref_clk) ptr_req <= '{1'b1, 2'h0, SIC_PTR_POSTINC, 6'h00};
    @(posedge ref_clk) ptr_req <= '0;
    #1;
    chk("paddr", x, ptr_addr);
    chk("xinc", x + 16'h0001, ptr_pairs[15:0]);
    $display("test pointer done");
    a = $urandom_range(6);
    io(1'b1, SIC_IO_IRQ_ENABLE, 8'hFF);
    ev(8'h03 << a);
    instr(1'b1, 1'b0);
    chkb("take", 1'b0, irq_take);
    chkb("gie", 1'b1, global_irq_enable);
    instr(1'b0, 1'b0);
    chkb("take", 1'b0, irq_take);
    instr(1'b0, 1'b0);
    chkb("take", 1'b1, irq_take);
    chk("vec", 16'(a + 1), irq_vector);
    chkb("gie", 1'b0, global_irq_enable);
    chk("sp", nsp(SIC_STK_CALL, sp), stack_pointer);
    wt(3);
    chkb("busy", 1'b1, core_busy);
    wt(1);
    chkb("busy", 1'b0, core_busy);
    io(1'b0, SIC_IO_IRQ_FLAGS, 8'h00);
    chk("flags", 16'(8'h02 << a), {8'h00, io_rdata});
    stk(SIC_STK_INTERRUPT_EXIT_INSTR);
    chk("sp", sp, stack_pointer);
    wt(4);
    chkb("gie", 1'b1, global_irq_enable);
    instr(1'b0, 1'b0);
    chkb("take", 1'b0, irq_take);
    instr(1'b0, 1'b0);
    chkb("take", 1'b1, irq_take);
    chk("vec", 16'(a + 2), irq_vector);
    wt(5);
    ev(8'h01 << a);
    io(1'b1, SIC_IO_IRQ_FLAGS, 8'h01 << a);
    io(1'b0, SIC_IO_IRQ_FLAGS, 8'h00);
    chk("flags", 16'h0000, {8'h00, io_rdata});
    ev(8'h01 << a);
    io(1'b1, SIC_IO_STATUS, 8'h80);
    instr(1'b0, 1'b1);
    chkb("take", 1'b0, irq_take);
    $display("test interrupt done");
    close_out();
  end
endmodule // sic_core_tb
`default_nettype wire
